// ==== rtl/trace_ram_controller.sv ====
// System RAM controller with program-flow trace recording
module trace_ram_controller #(
	parameter int unsigned RAM_WORDS = trace_ram_pkg::RAM_WORDS_DEF,
	parameter int unsigned CMPS = trace_ram_pkg::CMP_COUNT
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic HREADYOUT,
	output logic [31:0] HRDATA,
	output logic HRESP,
	input wire logic [30:0] EXEC_STAGE_HALFWORD_ADDR,
	input wire logic EXEC_ADDR_UPDATE_EN,
	input wire logic NEXT_ADDR_SEQUENTIAL,
	input wire logic ATOMIC,
	input wire logic LOCKUP,
	output logic DEBUG_HALT_REQUEST,
	input wire logic TRACE_ENABLE,
	input wire logic HALT_ON_WRAP,
	input wire logic [31:0] TRACE_BASE,
	input wire logic [31:0] TRACE_SIZE_MASK,
	input wire logic POS_WR_EN,
	input wire logic [31:0] POS_WR_PTR,
	input wire logic POS_WR_WRAP,
	output logic [31:0] POS_PTR,
	output logic POS_WRAP,
	output logic TRACE_ACTIVE,
	output logic TRACE_OVERFLOW,
	input wire logic WP_BUS_VALID,
	input wire logic [31:0] WP_BUS_ADDR,
	input wire logic [31:0] WP_BUS_DATA,
	input wire logic [CMPS-1:0] WP_CMP_ENABLE,
	input wire logic [CMPS-1:0][31:0] WP_CMP_ADDR,
	input wire logic [CMPS-1:0][31:0] WP_CMP_DATA,
	input wire logic [CMPS-1:0] WP_CMP_DATA_EN,
	input wire logic [CMPS-1:0] WP_CMP_IS_BEGIN
);

	localparam int unsigned AW = $clog2(RAM_WORDS);

	// ==========================================================
	// Elaboration checks
	if (RAM_WORDS < 4 || (RAM_WORDS & (RAM_WORDS - 1)) != 0) begin : g_chk_words
		$error("RAM_WORDS must be a power of two, at least 4");
	end
	if (CMPS != trace_ram_pkg::CMP_COUNT) begin : g_chk_cmps
		$error("CMPS must equal the comparator count");
	end

	// ==========================================================
	// Declarations
	logic new_ap, wr_done, rd_wait, rd_need;
	logic tr_go, drain_go, live_go, rd_go;
	logic [AW-1:0] rd_idx;
	logic dph_v_q, dph_v_d, dph_wr_q, dph_wr_d;
	logic [AW-1:0] dph_idx_q, dph_idx_d;
	logic [3:0] dph_strb_q, dph_strb_d;
	logic hready_q, hready_d, hresp_q;
	logic wb_v_q, wb_v_d;
	logic [AW-1:0] wb_idx_q, wb_idx_d;
	logic [3:0] wb_strb_q, wb_strb_d;
	logic [31:0] wb_data_q, wb_data_d;
	logic ram_en, ram_we;
	logic [3:0] ram_strb;
	logic [AW-1:0] ram_idx;
	logic [31:0] ram_wdata, ram_rdata;
	trace_ram_pkg::trace_wr_t tw_q, tw_d;
	logic [31:0] pk_src_q, pk_src_d, pk_dst_q, pk_dst_d;
	logic [AW-1:0] pk_idx_q, pk_idx_d;
	logic [30:0] prev_q, prev_d;
	logic rec_q, rec_d, en_q, en_d, first_q, first_d;
	logic [31:0] ptr_q, ptr_d, ptr_next, trace_addr;
	logic wrap_q, wrap_d, ovf_q, ovf_d, halt_q, halt_d;
	logic cof, capture, slot_free, wrap_evt;
	logic begin_trig, end_trig;

	// ==========================================================
	// Watchpoint triggers and RAM array
	watchpoint_trigger_unit #(.CMPS(CMPS)) u_wpt (
		.clk(CLK),
		.rst_n(RST_N),
		.bus_valid(WP_BUS_VALID),
		.bus_addr(WP_BUS_ADDR),
		.bus_data(WP_BUS_DATA),
		.cmp_enable(WP_CMP_ENABLE),
		.cmp_addr(WP_CMP_ADDR),
		.cmp_data(WP_CMP_DATA),
		.cmp_data_en(WP_CMP_DATA_EN),
		.cmp_is_begin(WP_CMP_IS_BEGIN),
		.trace_begin_trigger(begin_trig),
		.trace_end_trigger(end_trig)
	);

	trace_sram #(.WORDS(RAM_WORDS), .AW(AW)) u_ram (
		.clk(CLK),
		.en(ram_en),
		.we(ram_we),
		.strb(ram_strb),
		.idx(ram_idx),
		.wdata(ram_wdata),
		.rdata(ram_rdata)
	);

	// ==========================================================
	// Bus phase decode and port arbitration
	// Trace words first, then the posted write, then live write data, then reads;
	// a read never passes a write, so it always sees the newest data.
	always_comb begin
		new_ap = HSEL && HTRANS[trace_ram_pkg::HTRANS_ACTIVE_BIT] && HREADY;
		wr_done = dph_v_q && dph_wr_q && hready_q;
		rd_wait = dph_v_q && !dph_wr_q && !hready_q;
		rd_need = rd_wait || (new_ap && !HWRITE);
		tr_go = (tw_q != trace_ram_pkg::TW_IDLE);
		drain_go = !tr_go && wb_v_q;
		live_go = !tr_go && !wb_v_q && wr_done;
		rd_go = !tr_go && !wb_v_q && !wr_done && rd_need;
		rd_idx = rd_wait ? dph_idx_q : HADDR[AW+1:2];
	end

	// RAM port mux; the trace path only ever writes
	always_comb begin
		ram_en = tr_go || drain_go || live_go || rd_go;
		ram_we = tr_go || drain_go || live_go;
		ram_strb = 4'hf;
		ram_idx = rd_idx;
		ram_wdata = pk_src_q;
		if (tw_q == trace_ram_pkg::TW_LO) begin
			ram_idx = pk_idx_q;
			ram_wdata = pk_src_q;
		end else if (tw_q == trace_ram_pkg::TW_HI) begin
			ram_idx = {pk_idx_q[AW-1:1], 1'b1};
			ram_wdata = pk_dst_q;
		end else if (drain_go) begin
			ram_idx = wb_idx_q;
			ram_strb = wb_strb_q;
			ram_wdata = wb_data_q;
		end else if (live_go) begin
			ram_idx = dph_idx_q;
			ram_strb = dph_strb_q;
			ram_wdata = HWDATA;
		end
	end

	// ==========================================================
	// Bus slave next state
	// The held data phase plus the posted write form the two pending transfers; an address
	// the master keeps on the bus during a wait is taken only once HREADY is high.
	always_comb begin
		wb_v_d = wb_v_q;
		wb_idx_d = wb_idx_q;
		wb_strb_d = wb_strb_q;
		wb_data_d = wb_data_q;
		if (wr_done && !live_go) begin
			wb_v_d = 1'b1;
			wb_idx_d = dph_idx_q;
			wb_strb_d = dph_strb_q;
			wb_data_d = HWDATA;
		end else if (drain_go) begin
			wb_v_d = 1'b0;
		end
		dph_v_d = dph_v_q;
		dph_wr_d = dph_wr_q;
		dph_idx_d = dph_idx_q;
		dph_strb_d = dph_strb_q;
		if (new_ap) begin
			dph_v_d = 1'b1;
			dph_wr_d = HWRITE;
			dph_idx_d = HADDR[AW+1:2];
			dph_strb_d = trace_ram_pkg::ahb_strobes(HSIZE, HADDR[1:0]);
		end else if (dph_v_q && hready_q) begin
			dph_v_d = 1'b0;
		end
		// Ready for the coming data phase only when its RAM slot is certain
		if (!dph_v_d) begin
			hready_d = 1'b1;
		end else if (dph_wr_d) begin
			hready_d = !wb_v_d;
		end else begin
			hready_d = rd_go;
		end
	end

	// Bus slave registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			dph_v_q <= 1'b0;
			dph_wr_q <= 1'b0;
			dph_idx_q <= '0;
			dph_strb_q <= 4'h0;
			hready_q <= trace_ram_pkg::HREADY_RST;
			hresp_q <= trace_ram_pkg::HRESP_OKAY;
			wb_v_q <= 1'b0;
			wb_idx_q <= '0;
			wb_strb_q <= 4'h0;
			wb_data_q <= 32'h0000_0000;
		end else begin
			dph_v_q <= dph_v_d;
			dph_wr_q <= dph_wr_d;
			dph_idx_q <= dph_idx_d;
			dph_strb_q <= dph_strb_d;
			hready_q <= hready_d;
			hresp_q <= trace_ram_pkg::HRESP_OKAY;
			wb_v_q <= wb_v_d;
			wb_idx_q <= wb_idx_d;
			wb_strb_q <= wb_strb_d;
			wb_data_q <= wb_data_d;
		end
	end

	// ==========================================================
	// Change-of-flow capture and recording state
	always_comb begin
		// Non-sequential update; flows while locked up are not traced
		cof = EXEC_ADDR_UPDATE_EN && !NEXT_ADDR_SEQUENTIAL && !LOCKUP;
		capture = cof && rec_q;
		slot_free = (tw_q == trace_ram_pkg::TW_IDLE) || (tw_q == trace_ram_pkg::TW_HI);
		en_d = TRACE_ENABLE;
		// Begin wins over end when both fire together
		if (!TRACE_ENABLE) begin
			rec_d = 1'b0;
		end else if ((TRACE_ENABLE && !en_q) || begin_trig) begin
			rec_d = 1'b1;
		end else if (end_trig) begin
			rec_d = 1'b0;
		end else begin
			rec_d = rec_q;
		end
		// Every stopped-to-recording edge arms the start flag again
		if (rec_d && !rec_q) begin
			first_d = 1'b1;
		end else if (capture && slot_free) begin
			first_d = 1'b0;
		end else begin
			first_d = first_q;
		end
		prev_d = EXEC_ADDR_UPDATE_EN ? EXEC_STAGE_HALFWORD_ADDR : prev_q;
	end

	// ==========================================================
	// Packet build, pointer and trace writer
	// Source is the address before the update and destination the new one; the core
	// presents the return code as an execute address to split an exception return.
	always_comb begin
		trace_addr = (TRACE_BASE & trace_ram_pkg::PKT_ALIGN_MASK)
			+ (ptr_q & TRACE_SIZE_MASK & trace_ram_pkg::PKT_ALIGN_MASK);
		ptr_next = (ptr_q + trace_ram_pkg::PKT_BYTES) & TRACE_SIZE_MASK
			& trace_ram_pkg::PKT_ALIGN_MASK;
		wrap_evt = 1'b0;
		tw_d = tw_q;
		pk_src_d = pk_src_q;
		pk_dst_d = pk_dst_q;
		pk_idx_d = pk_idx_q;
		ptr_d = ptr_q;
		wrap_d = wrap_q;
		ovf_d = ovf_q;
		halt_d = halt_q;
		case (tw_q)
			trace_ram_pkg::TW_LO: tw_d = trace_ram_pkg::TW_HI;
			trace_ram_pkg::TW_HI: tw_d = trace_ram_pkg::TW_IDLE;
			default: tw_d = trace_ram_pkg::TW_IDLE;
		endcase
		if (capture && slot_free) begin
			pk_src_d = {prev_q, ATOMIC};
			pk_dst_d = {EXEC_STAGE_HALFWORD_ADDR, first_q};
			pk_idx_d = trace_addr[AW+1:2];
			tw_d = trace_ram_pkg::TW_LO;
			ptr_d = ptr_next;
			wrap_evt = (ptr_next == 32'h0000_0000);
		end
		// A packet arriving while the previous one still writes its first word is dropped and flagged
		if (POS_WR_EN) begin
			ptr_d = POS_WR_PTR & trace_ram_pkg::PKT_ALIGN_MASK;
			wrap_d = POS_WR_WRAP;
			ovf_d = 1'b0;
			halt_d = 1'b0;
		end
		if (wrap_evt) begin
			wrap_d = 1'b1;
		end
		if (capture && !slot_free) begin
			ovf_d = 1'b1;
		end
		if (wrap_evt && HALT_ON_WRAP) begin
			halt_d = 1'b1;
		end
	end

	// Trace registers
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			tw_q <= trace_ram_pkg::TW_IDLE;
			pk_src_q <= 32'h0000_0000;
			pk_dst_q <= 32'h0000_0000;
			pk_idx_q <= '0;
			prev_q <= trace_ram_pkg::PREV_ADDR_RST;
			rec_q <= 1'b0;
			en_q <= 1'b0;
			first_q <= 1'b0;
			ptr_q <= trace_ram_pkg::PTR_RST;
			wrap_q <= trace_ram_pkg::WRAP_RST;
			ovf_q <= 1'b0;
			halt_q <= 1'b0;
		end else begin
			tw_q <= tw_d;
			pk_src_q <= pk_src_d;
			pk_dst_q <= pk_dst_d;
			pk_idx_q <= pk_idx_d;
			prev_q <= prev_d;
			rec_q <= rec_d;
			en_q <= en_d;
			first_q <= first_d;
			ptr_q <= ptr_d;
			wrap_q <= wrap_d;
			ovf_q <= ovf_d;
			halt_q <= halt_d;
		end
	end

	// ==========================================================
	// Outputs
	assign HREADYOUT = hready_q;
	assign HRDATA = ram_rdata;
	assign HRESP = hresp_q;
	assign DEBUG_HALT_REQUEST = halt_q;
	assign POS_PTR = ptr_q;
	assign POS_WRAP = wrap_q;
	assign TRACE_ACTIVE = rec_q;
	assign TRACE_OVERFLOW = ovf_q;

endmodule

// ==== rtl/trace_ram_pkg.sv ====
// Shared constants and types for the trace RAM controller
package trace_ram_pkg;

	// ==========================================================
	// Sizes
	localparam int unsigned RAM_WORDS_DEF = 1024;
	localparam int unsigned CMP_COUNT = 2;

	// ==========================================================
	// System bus encodings
	localparam int unsigned HTRANS_ACTIVE_BIT = 1;
	localparam logic [2:0] HSIZE_BYTE = 3'h0;
	localparam logic [2:0] HSIZE_HALF = 3'h1;
	localparam logic HRESP_OKAY = 1'h0;

	// ==========================================================
	// Trace packet layout
	localparam logic [31:0] PKT_BYTES = 32'h0000_0008;
	localparam logic [31:0] PKT_ALIGN_MASK = 32'hffff_fff8;

	// ==========================================================
	// Reset values
	localparam logic [31:0] PTR_RST = 32'h0000_0000;
	localparam logic WRAP_RST = 1'h0;
	localparam logic HREADY_RST = 1'h1;
	localparam logic [30:0] PREV_ADDR_RST = 31'h0000_0000;

	// ==========================================================
	// Trace writer states
	typedef enum logic [1:0] {
		TW_IDLE,
		TW_LO,
		TW_HI
	} trace_wr_t;

	// Byte lanes of a bus write from its size and low address bits
	function automatic logic [3:0] ahb_strobes(input logic [2:0] size, input logic [1:0] a);
		case (size)
			HSIZE_BYTE: ahb_strobes = 4'h1 << a;
			HSIZE_HALF: ahb_strobes = a[1] ? 4'hc : 4'h3;
			default: ahb_strobes = 4'hf;
		endcase
	endfunction

endpackage

// ==== rtl/trace_sram.sv ====
// Single-port RAM array with byte lanes and a registered read port
module trace_sram #(
	parameter int unsigned WORDS = 1024,
	parameter int unsigned AW = 10
) (
	input wire logic clk,
	input wire logic en,
	input wire logic we,
	input wire logic [3:0] strb,
	input wire logic [AW-1:0] idx,
	input wire logic [31:0] wdata,
	output logic [31:0] rdata
);

	// ==========================================================
	// Storage
	logic [31:0] mem [WORDS];
	logic [31:0] rdata_q;

	// Read data changes only on a read, so it stands through wait states
	always_ff @(posedge clk) begin
		if (en && !we) begin
			rdata_q <= mem[idx];
		end
	end

	// One write enable per byte lane
	for (genvar b = 0; b < 4; b++) begin : g_lane
		always_ff @(posedge clk) begin
			if (en && we && strb[b]) begin
				mem[idx][8*b +: 8] <= wdata[8*b +: 8];
			end
		end
	end

	assign rdata = rdata_q;

endmodule

// ==== rtl/watchpoint_trigger_unit.sv ====
// Two address or address-plus-data comparators giving trace begin and end triggers
module watchpoint_trigger_unit #(
	parameter int unsigned CMPS = trace_ram_pkg::CMP_COUNT
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic bus_valid,
	input wire logic [31:0] bus_addr,
	input wire logic [31:0] bus_data,
	input wire logic [CMPS-1:0] cmp_enable,
	input wire logic [CMPS-1:0][31:0] cmp_addr,
	input wire logic [CMPS-1:0][31:0] cmp_data,
	input wire logic [CMPS-1:0] cmp_data_en,
	input wire logic [CMPS-1:0] cmp_is_begin,
	output logic trace_begin_trigger,
	output logic trace_end_trigger
);

	// ==========================================================
	// Comparators
	logic [CMPS-1:0] hit;
	logic begin_d, begin_q, end_d, end_q;

	// Each comparator matches the address, and the data too when asked
	for (genvar i = 0; i < CMPS; i++) begin : g_cmp
		assign hit[i] = bus_valid && cmp_enable[i] && (bus_addr == cmp_addr[i])
			&& (!cmp_data_en[i] || bus_data == cmp_data[i]);
	end

	// Sort the hits into begin and end requests
	always_comb begin
		begin_d = |(hit & cmp_is_begin);
		end_d = |(hit & ~cmp_is_begin);
	end

	// Trigger pulses registered one cycle behind the hits, as long as the hits last
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			begin_q <= 1'b0;
			end_q <= 1'b0;
		end else begin
			begin_q <= begin_d;
			end_q <= end_d;
		end
	end

	assign trace_begin_trigger = begin_q;
	assign trace_end_trigger = end_q;

endmodule

// ==== verif/trace_ram_props.sv ====
// Port-level concurrent checks for the trace RAM controller
module trace_ram_props (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic HSEL,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic HREADYOUT,
	input wire logic HRESP,
	input wire logic EXEC_ADDR_UPDATE_EN,
	input wire logic NEXT_ADDR_SEQUENTIAL,
	input wire logic LOCKUP,
	input wire logic TRACE_ENABLE,
	input wire logic HALT_ON_WRAP,
	input wire logic [31:0] TRACE_SIZE_MASK,
	input wire logic POS_WR_EN,
	input wire logic [31:0] POS_WR_PTR,
	input wire logic [31:0] POS_PTR,
	input wire logic POS_WRAP,
	input wire logic TRACE_ACTIVE,
	input wire logic TRACE_OVERFLOW,
	input wire logic DEBUG_HALT_REQUEST
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic cap;
	// ==========================================================
	// Capture condition and packet sequences
	assign cap = EXEC_ADDR_UPDATE_EN && !NEXT_ADDR_SEQUENTIAL && !LOCKUP && TRACE_ACTIVE;
	sequence take_s;
		!cap ##1 (cap && !POS_WR_EN);
	endsequence
	sequence quiet_s;
		!TRACE_ACTIVE && !(HSEL && HTRANS[1] && HWRITE);
	endsequence
	AST_HRESP_OKAY: assert property (HRESP == trace_ram_pkg::HRESP_OKAY)
		else $error("bus response not okay");
	AST_ZERO_WAIT: assert property (quiet_s [*4] |=> HREADYOUT)
		else $error("wait state without trace or write");
	AST_PTR_STEP: assert property (take_s |=> POS_PTR == (($past(POS_PTR) + 32'h8) & TRACE_SIZE_MASK))
		else $error("pointer did not step by one packet");
	AST_PTR_HOLD: assert property (!cap && !POS_WR_EN |=> $stable(POS_PTR))
		else $error("pointer moved without a capture");
	AST_PTR_LOAD: assert property (POS_WR_EN |=> POS_PTR == ($past(POS_WR_PTR) & 32'hffff_fff8))
		else $error("pointer load wrong");
	AST_OVERFLOW: assert property (take_s ##1 (cap && !POS_WR_EN) |=> TRACE_OVERFLOW)
		else $error("dropped packet not flagged");
	AST_WRAP: assert property (take_s ##0 (((POS_PTR + 32'h8) & TRACE_SIZE_MASK) == 32'h0) |=>
		POS_WRAP && (!$past(HALT_ON_WRAP) || DEBUG_HALT_REQUEST))
		else $error("wrap or halt not raised");
	AST_HALT_HOLD: assert property (DEBUG_HALT_REQUEST && !POS_WR_EN |=> DEBUG_HALT_REQUEST)
		else $error("halt request dropped");
	AST_STOP: assert property (!TRACE_ENABLE [*2] |-> !TRACE_ACTIVE)
		else $error("recording while disabled");
endmodule

bind trace_ram_controller trace_ram_props u_props (.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL),
	.HTRANS(HTRANS), .HWRITE(HWRITE), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.EXEC_ADDR_UPDATE_EN(EXEC_ADDR_UPDATE_EN), .NEXT_ADDR_SEQUENTIAL(NEXT_ADDR_SEQUENTIAL),
	.LOCKUP(LOCKUP), .TRACE_ENABLE(TRACE_ENABLE), .HALT_ON_WRAP(HALT_ON_WRAP),
	.TRACE_SIZE_MASK(TRACE_SIZE_MASK), .POS_WR_EN(POS_WR_EN), .POS_WR_PTR(POS_WR_PTR),
	.POS_PTR(POS_PTR), .POS_WRAP(POS_WRAP), .TRACE_ACTIVE(TRACE_ACTIVE),
	.TRACE_OVERFLOW(TRACE_OVERFLOW), .DEBUG_HALT_REQUEST(DEBUG_HALT_REQUEST));

// ==== verif/core_trace_model.sv ====
// Behavioural model of the core execution trace port
module core_trace_model (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic run,
	input wire logic burst,
	output logic [30:0] addr,
	output logic upd,
	output logic seq,
	output logic atomic,
	output logic lockup
);
	timeunit 1ns;
	timeprecision 1ps;
	int seed;
	int r;
	int gap;
	logic ret;
	// Core starts idle, out of lockup
	initial begin
		seed = 73;
		addr = 31'h0000_0800;
		upd = 1'h0;
		seq = 1'h1;
		atomic = 1'h0;
		lockup = 1'h0;
		gap = 2;
		ret = 1'h0;
	end
	// One execute step per cycle; branches spaced two apart unless burst
	always @(negedge clk) begin
		r = $random(seed);
		upd = rst_n && run && (r[0] || burst);
		seq = 1'h1;
		atomic = 1'h0;
		lockup = !burst && r[9:6] == 4'h0;
		gap = gap + 1;
		if (upd && (burst || (gap > 1 && (ret || r[2:1] == 2'h0)))) begin
			seq = 1'h0;
			gap = 0;
			if (ret) begin
				addr = {15'h0, r[31:16]};
				atomic = 1'h1;
				ret = 1'h0;
			end else if (r[4:3] == 2'h0) begin
				addr = 31'h7fff_fffc;
				ret = 1'h1;
			end else begin
				addr = {15'h0, r[31:16]};
				atomic = r[5];
			end
		end else if (upd && !ret) addr = addr + 31'h1;
		else upd = 1'h0;
	end
endmodule

// ==== verif/tb.sv ====
// Self-checking bench for the trace RAM controller
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, rst_n, hsel, hwrite, upd, seq, atom, lock, ten, how, pwe, pww, wpv, run, burst;
	logic hro, hresp, halt, pwrap, act, ovf, acc, acc_r, on_r, start_r, wrap_r, ovf_r, halt_r;
	logic [1:0] htrans, cen, cden, cbeg;
	logic [2:0] hsize, sz;
	logic [30:0] xaddr, prev_r;
	logic [31:0] haddr, hwdata, hrdata, base, smask, pwp, pptr, wpa, wpd, rd, a, d, ptr_r;
	logic [1:0][31:0] caddr, cdata;
	logic [31:0] mem [0:127];
	logic [31:0] tmem [0:15];
	int n_mismatch, cmp_count, seed, w, i;
	trace_ram_controller dut (.CLK(clk), .RST_N(rst_n), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hro),
		.HREADYOUT(hro), .HRDATA(hrdata), .HRESP(hresp), .EXEC_STAGE_HALFWORD_ADDR(xaddr),
		.EXEC_ADDR_UPDATE_EN(upd), .NEXT_ADDR_SEQUENTIAL(seq), .ATOMIC(atom), .LOCKUP(lock),
		.DEBUG_HALT_REQUEST(halt), .TRACE_ENABLE(ten), .HALT_ON_WRAP(how), .TRACE_BASE(base),
		.TRACE_SIZE_MASK(smask), .POS_WR_EN(pwe), .POS_WR_PTR(pwp), .POS_WR_WRAP(pww),
		.POS_PTR(pptr), .POS_WRAP(pwrap), .TRACE_ACTIVE(act), .TRACE_OVERFLOW(ovf),
		.WP_BUS_VALID(wpv), .WP_BUS_ADDR(wpa), .WP_BUS_DATA(wpd), .WP_CMP_ENABLE(cen),
		.WP_CMP_ADDR(caddr), .WP_CMP_DATA(cdata), .WP_CMP_DATA_EN(cden), .WP_CMP_IS_BEGIN(cbeg));
	core_trace_model core (.clk(clk), .rst_n(rst_n), .run(run), .burst(burst), .addr(xaddr),
		.upd(upd), .seq(seq), .atomic(atom), .lockup(lock));
	// ==========================================================
	// Checking helpers
	task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask
	task close_out;
		$display("mismatches %0d compares %0d", n_mismatch, cmp_count);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	function automatic logic [31:0] merge(logic [31:0] o, logic [2:0] s, logic [1:0] b,
		logic [31:0] v);
		logic [31:0] m;
		m = s == 3'h0 ? 32'hff << {b, 3'h0} : s == 3'h1 ? 32'hffff << {b[1], 4'h0} : 32'hffff_ffff;
		return (o & ~m) | (v & m);
	endfunction
	// One pipelined transfer, entered at a falling edge; counts data-phase waits.
	// The address stays up until the caller issues the next transfer or idles the bus.
	task bus(input logic wr, input logic [2:0] s, input logic [31:0] ad, input logic [31:0] wd);
		hsel = 1'h1;
		htrans = 2'h2;
		hwrite = wr;
		hsize = s;
		haddr = ad;
		while (!hro) @(negedge clk);
		@(negedge clk);
		hwdata = wd;
		w = 0;
		while (!hro) begin
			w++;
			@(negedge clk);
		end
		rd = hrdata;
	endtask
	task wp(input logic [31:0] ad, input logic [31:0] dv, input logic was, input logic now);
		wpa = ad;
		wpd = dv;
		wpv = 1'h1;
		@(negedge clk);
		wpv = 1'h0;
		chk({31'h0, act}, {31'h0, was}, "trigger early");
		@(negedge clk);
		chk({31'h0, act}, {31'h0, now}, "trigger");
		@(negedge clk);
	endtask
	// ==========================================================
	// Reference packet writer, watching the trace port at each rising edge
	always @(posedge clk) begin
		acc = 1'h0;
		if (upd && !seq && !lock && on_r) begin
			if (acc_r) ovf_r = 1'h1;
			else begin
				tmem[ptr_r[5:2]] = {prev_r, atom};
				tmem[ptr_r[5:2] + 4'h1] = {xaddr, start_r};
				start_r = 1'h0;
				acc = 1'h1;
				ptr_r = (ptr_r + 32'h8) & smask;
				if (ptr_r == 32'h0) begin
					wrap_r = 1'h1;
					halt_r = halt_r | how;
				end
			end
		end
		if (upd) prev_r = xaddr;
		acc_r = acc;
	end
	initial begin
		clk = 1'h0;
		forever #10 clk = ~clk;
	end
	// Watchdog sized well past the longest expected run
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		close_out;
	end
	initial begin
		{rst_n, hsel, hwrite, ten, pwe, pww, wpv, run, burst, on_r, acc_r} = 11'h0;
		{htrans, haddr, hwdata, pwp, wpa, wpd, ptr_r, prev_r} = 'h0;
		{hsize, how, base, smask, seed} = {3'h2, 1'h1, 32'h200, 32'h3f, 32'h49};
		{cen, cden, cbeg} = 6'h39;
		caddr = {32'h4000_0020, 32'h4000_0010};
		cdata = {32'h0000_00a5, 32'h0};
		repeat (16) @(negedge clk);
		rst_n = 1'h1;
		chk({27'h0, hro, hresp, act, ovf, halt}, 32'h10, "reset");
		chk(pptr, 32'h0, "reset ptr");
		for (i = 0; i < 144; i++) begin
			d = i < 128 ? $random(seed) : 32'h0;
			if (i < 128) mem[i] = d;
			else tmem[i - 128] = d;
			bus(1'h1, 3'h2, i < 128 ? 32'(i) << 2 : base + (32'(i - 128) << 2), d);
			chk(32'(w), 32'h0, "write wait");
		end
		for (i = 0; i < 8; i++) begin
			a = 32'($random(seed)) & (i[0] ? 32'h1ff : 32'h1fe);
			sz = i[0] ? 3'h0 : 3'h1;
			d = $random(seed);
			mem[a[8:2]] = merge(mem[a[8:2]], sz, a[1:0], d);
			bus(1'h1, sz, a, d);
		end
		bus(1'h1, 3'h2, 32'(trace_ram_pkg::RAM_WORDS_DEF * 4) + 32'h8, 32'h5a5a_0f0f);
		mem[2] = 32'h5a5a_0f0f;
		for (i = 0; i < 32; i++) begin
			a = i == 0 ? 32'h8 : 32'($random(seed)) & 32'h1fc;
			bus(1'h0, 3'h2, a, 32'h0);
			chk(rd, mem[a[8:2]], "read");
			if (i > 0) chk(32'(w), 32'h0, "read wait");
		end
		// ==========================================================
		// Trace recording alongside bus traffic, ending with a burst
		{hsel, htrans} = 3'h0;
		pwe = 1'h1;
		@(negedge clk);
		pwe = 1'h0;
		{ptr_r, wrap_r, ovf_r, halt_r, start_r, ten} = {32'h0, 4'h1, 1'h1};
		repeat (3) @(negedge clk);
		{on_r, run} = 2'h3;
		for (i = 0; i < 40; i++) begin
			a = 32'($random(seed)) & 32'h1fc;
			d = $random(seed);
			if (d[0]) mem[a[8:2]] = d;
			bus(d[0], 3'h2, a, d);
			if (!d[0]) chk(rd, mem[a[8:2]], "read in trace");
		end
		{hsel, htrans} = 3'h0;
		burst = 1'h1;
		repeat (2) @(negedge clk);
		{burst, run} = 2'h0;
		repeat (3) @(negedge clk);
		on_r = 1'h0;
		chk({28'h0, pwrap, ovf, halt, act}, {28'h0, wrap_r, ovf_r, halt_r, 1'h1}, "flags");
		chk(pptr, ptr_r, "ptr");
		for (i = 0; i < 16; i++) begin
			bus(1'h0, 3'h2, base + (32'(i) << 2), 32'h0);
			chk(rd, tmem[i], "packet word");
		end
		{hsel, htrans} = 3'h0;
		wp(32'h4000_0020, 32'h0000_005a, 1'h1, 1'h1);
		wp(32'h4000_0020, 32'h0000_00a5, 1'h1, 1'h0);
		wp(32'h4000_0010, 32'h0000_0000, 1'h0, 1'h1);
		{pwe, pww, pwp} = {2'h3, 32'h1f};
		@(negedge clk);
		pwe = 1'h0;
		ten = 1'h0;
		chk(pptr, 32'h18, "ptr load");
		chk({29'h0, pwrap, ovf, halt}, 32'h4, "load flags");
		repeat (3) @(negedge clk);
		close_out;
	end
endmodule
